// ### rtl/asr_reset_ctrl.sv
// Soft and hard reset control for a two-channel converter
`timescale 1ns/10ps
`default_nettype none
`include "asr_cfg.svh"

// Overview of operation
// - Soft reset entered only in SPI mode by setting per-channel soft reset bits.
// - Channel in soft reset keeps converting but presents zero output.
// - Soft reset keeps all registers except that channel's result register, cleared, and settle counter, reloaded.
// - After soft reset exit, valid data follows filter settling with no extra delay.
// - Soft reset is controlled separately per channel.
// - No data-ready pulse from a channel held in soft reset.
// - Exiting channel keeps phase delay and realigns to the running channel.
// - Soft reset of one channel never stops the internal clock.
// - With both channels in soft reset the input structure stays clocked.
// - Hard reset only from power-on reset or low reset pin in SPI mode.
// - Hard reset clears channel state, results and soft bits; pin synchroniser keeps running.
// - In two-wire mode the reset pin has no effect.
// - Hard reset clears all conversion data.
// - Hard reset forces comparator outputs to 0011.
// - Hard reset resets decimation filters and their double buffers.
// - Serial interface held in reset during hard reset.
// - Hard reset keeps analog bias enables active.
module asr_reset_ctrl
   import asr_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic POR,
   input wire logic RESET_N_PIN,
   input wire logic SPI_MODE,
   input wire logic [1:0] SOFT_RESET_BITS,
   input wire logic [`ASR_SETTLE_W-1:0] SETTLE_CYCLES,
   input wire logic [`ASR_DW-1:0] CONV0_DATA,
   input wire logic [`ASR_DW-1:0] CONV1_DATA,
   input wire logic CONV0_STROBE,
   input wire logic CONV1_STROBE,
   input wire logic [`ASR_CMP_W-1:0] CMP0_IN,
   input wire logic [`ASR_CMP_W-1:0] CMP1_IN,
   output logic [`ASR_DW-1:0] RESULT0,
   output logic [`ASR_DW-1:0] RESULT1,
   output logic DRDY0,
   output logic DRDY1,
   output logic [`ASR_CMP_W-1:0] CMP0_OUT,
   output logic [`ASR_CMP_W-1:0] CMP1_OUT,
   output logic [1:0] CH_SOFT_RESET,
   output logic [1:0] CH_CONV_EN,
   output logic [1:0] CH_RESYNC,
   output logic FILTER_RST,
   output logic SERIAL_RST,
   output logic BIAS_EN,
   output logic INPUT_CLK_EN,
   output logic HARD_RESET
);

   // Pin synchroniser: three stages, change accepted when stages two and three agree
   logic [2:0] pin_sync_q;
   logic [2:0] pin_sync_d;
   logic pin_filt_q;
   logic pin_filt_d;
   logic hard_q;
   logic hard_d;
   asr_state_e st_q [`ASR_NCH];
   asr_state_e st_d [`ASR_NCH];
   logic [`ASR_DW-1:0] res_q [`ASR_NCH];
   logic [`ASR_DW-1:0] res_d [`ASR_NCH];
   logic [`ASR_SETTLE_W-1:0] cnt_q [`ASR_NCH];
   logic [`ASR_SETTLE_W-1:0] cnt_d [`ASR_NCH];
   logic [1:0] drdy_q;
   logic [1:0] drdy_d;
   logic [1:0] soft_q;
   logic [1:0] soft_d;
   logic [`ASR_DW-1:0] conv_data [`ASR_NCH];
   logic [1:0] conv_stb;
   logic [`ASR_CMP_W-1:0] cmp_in [`ASR_NCH];

   assign conv_data[0] = CONV0_DATA;
   assign conv_data[1] = CONV1_DATA;
   assign conv_stb = {CONV1_STROBE, CONV0_STROBE};
   assign cmp_in[0] = CMP0_IN;
   assign cmp_in[1] = CMP1_IN;

   always_comb begin
      pin_sync_d = {pin_sync_q[1:0], RESET_N_PIN};
      pin_filt_d = pin_filt_q;
      if (pin_sync_q[2] == pin_sync_q[1]) begin
         pin_filt_d = pin_sync_q[2];
      end
      // Pin counts only in SPI mode; two-wire mode ignores it
      hard_d = POR | (SPI_MODE & ~pin_filt_q);
      // Soft bits accepted only in SPI mode; held otherwise
      soft_d = soft_q;
      if (SPI_MODE) begin
         soft_d = SOFT_RESET_BITS;
      end
      if (hard_d) begin
         soft_d = 2'b00;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pin_sync_q <= 3'b111;
         pin_filt_q <= 1'b1;
         hard_q <= 1'b1;
         soft_q <= 2'b00;
      end else if (CE) begin
         pin_sync_q <= pin_sync_d;
         pin_filt_q <= pin_filt_d;
         hard_q <= hard_d;
         soft_q <= soft_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `ASR_NCH; gi++) begin : g_ch
         always_comb begin
            st_d[gi] = st_q[gi];
            res_d[gi] = res_q[gi];
            cnt_d[gi] = cnt_q[gi];
            drdy_d[gi] = 1'b0;
            case (st_q[gi])
               ASR_ST_HARD: begin
                  // Data, filters and buffers cleared while hard reset holds
                  res_d[gi] = '0;
                  cnt_d[gi] = SETTLE_CYCLES;
                  if (!hard_q) begin
                     st_d[gi] = soft_q[gi] ? ASR_ST_SOFT : ASR_ST_RUN;
                  end
               end
               ASR_ST_SOFT: begin
                  // Own bit only: channels are independent
                  res_d[gi] = '0;
                  cnt_d[gi] = SETTLE_CYCLES;
                  if (!soft_q[gi]) begin
                     st_d[gi] = ASR_ST_RUN;
                  end
               end
               ASR_ST_RUN: begin
                  if (soft_q[gi]) begin
                     st_d[gi] = ASR_ST_SOFT;
                     res_d[gi] = '0;
                  end else if (conv_stb[gi]) begin
                     // First strobe after settling is delivered, no extra delay
                     if (cnt_q[gi] == '0) begin
                        res_d[gi] = conv_data[gi];
                        drdy_d[gi] = 1'b1;
                     end
                  end
                  if (!soft_q[gi] && cnt_q[gi] != '0) begin
                     cnt_d[gi] = cnt_q[gi] - 1'b1;
                  end
               end
               default: begin
                  st_d[gi] = ASR_ST_HARD;
               end
            endcase
            if (hard_q) begin
               st_d[gi] = ASR_ST_HARD;
               res_d[gi] = '0;
               drdy_d[gi] = 1'b0;
            end
         end

         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               st_q[gi] <= ASR_ST_HARD;
               res_q[gi] <= '0;
               cnt_q[gi] <= `ASR_SETTLE_DEF;
               drdy_q[gi] <= 1'b0;
            end else if (CE) begin
               st_q[gi] <= st_d[gi];
               res_q[gi] <= res_d[gi];
               cnt_q[gi] <= cnt_d[gi];
               drdy_q[gi] <= drdy_d[gi];
            end
         end

         // Resynchronisation keeps phase setting; converter enable drops only in hard reset
         assign CH_RESYNC[gi] = (st_q[gi] == ASR_ST_SOFT) & ~soft_q[gi];
         assign CH_SOFT_RESET[gi] = (st_q[gi] == ASR_ST_SOFT);
         assign CH_CONV_EN[gi] = ~hard_q;
      end
   endgenerate

   assign RESULT0 = res_q[0];
   assign RESULT1 = res_q[1];
   // Soft reset suppresses data-ready
   assign DRDY0 = drdy_q[0];
   assign DRDY1 = drdy_q[1];
   // Comparators forced to fixed pattern
   assign CMP0_OUT = hard_q ? `ASR_CMP_RST : cmp_in[0];
   assign CMP1_OUT = hard_q ? `ASR_CMP_RST : cmp_in[1];
   assign FILTER_RST = hard_q;
   assign SERIAL_RST = hard_q;
   // Bias stays on so conversion starts right after release
   assign BIAS_EN = 1'b1;
   // Input structure clocked whenever the clock runs, even with both in soft reset
   assign INPUT_CLK_EN = 1'b1;
   assign HARD_RESET = hard_q;

   chk_hard_pattern: assert property (@(posedge CLK) disable iff (SYS_RST)
      hard_q |-> (CMP0_OUT == 4'h3 && CMP1_OUT == 4'h3))
      else $error("comparators not forced in hard reset");
   chk_soft_nodrdy: assert property (@(posedge CLK) disable iff (SYS_RST)
      CH_SOFT_RESET[0] |-> (!DRDY0 && RESULT0 == '0))
      else $error("drdy or data during soft reset ch0");
   chk_soft_nodrdy1: assert property (@(posedge CLK) disable iff (SYS_RST)
      CH_SOFT_RESET[1] |-> (!DRDY1 && RESULT1 == '0))
      else $error("drdy or data during soft reset ch1");
   chk_soft_enter: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && soft_q[0] && st_q[0] == ASR_ST_RUN && !hard_q) |=> (RESULT0 == '0))
      else $error("result not cleared on soft entry");
   chk_twowire_pin: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !POR && !SPI_MODE) |=> !hard_q)
      else $error("pin acted in two-wire mode");
   chk_pin_hard: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && SPI_MODE && !pin_filt_q) |=> hard_q)
      else $error("low pin did not hard reset");
   chk_hard_serial: assert property (@(posedge CLK) disable iff (SYS_RST)
      hard_q |-> (SERIAL_RST && FILTER_RST && BIAS_EN && !DRDY0 && !DRDY1))
      else $error("hard reset outputs wrong");
   chk_hard_data: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && hard_q) |=> (RESULT0 == '0 && RESULT1 == '0))
      else $error("data not cleared by hard reset");
   chk_ch_indep: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && SPI_MODE && !hard_d && SOFT_RESET_BITS == 2'b01) |=> (soft_q == 2'b01))
      else $error("soft bits not independent");
   // Hard reset rising in the same cycle gates the converters, so it is excluded here
   chk_both_clk: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CH_SOFT_RESET == 2'b11 && !hard_q) |-> (INPUT_CLK_EN && CH_CONV_EN == 2'b11))
      else $error("input clock stopped");
   chk_bias_on: assert property (@(posedge CLK) disable iff (SYS_RST)
      BIAS_EN)
      else $error("bias enable dropped");
   chk_ce_freeze: assert property (@(posedge CLK) disable iff (SYS_RST)
      !CE |=> ($stable(hard_q) && $stable(soft_q) && $stable(RESULT0)))
      else $error("state moved with clock enable low");
   chk_settle_wait0: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st_q[0] == ASR_ST_RUN && cnt_q[0] != '0) |=> !DRDY0)
      else $error("ch0 ready before settling");
   chk_settle_wait1: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st_q[1] == ASR_ST_RUN && cnt_q[1] != '0) |=> !DRDY1)
      else $error("ch1 ready before settling");
   chk_settle_go0: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !hard_q && st_q[0] == ASR_ST_RUN && !soft_q[0] && cnt_q[0] == '0 && CONV0_STROBE)
      |=> (DRDY0 && RESULT0 == $past(CONV0_DATA)))
      else $error("ch0 sample not delivered");
   chk_settle_go1: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !hard_q && st_q[1] == ASR_ST_RUN && !soft_q[1] && cnt_q[1] == '0 && CONV1_STROBE)
      |=> (DRDY1 && RESULT1 == $past(CONV1_DATA)))
      else $error("ch1 sample not delivered");
   chk_resync_once0: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && CH_RESYNC[0]) |=> !CH_RESYNC[0])
      else $error("ch0 resync longer than one cycle");
   chk_resync_once1: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && CH_RESYNC[1]) |=> !CH_RESYNC[1])
      else $error("ch1 resync longer than one cycle");
   chk_cmp_pass0: assert property (@(posedge CLK) disable iff (SYS_RST)
      !hard_q |-> (CMP0_OUT == CMP0_IN))
      else $error("ch0 comparators not passed through");
   chk_cmp_pass1: assert property (@(posedge CLK) disable iff (SYS_RST)
      !hard_q |-> (CMP1_OUT == CMP1_IN))
      else $error("ch1 comparators not passed through");
   chk_soft_enter1: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && soft_q[1] && st_q[1] == ASR_ST_RUN && !hard_q) |=> (RESULT1 == '0))
      else $error("ch1 result not cleared on soft entry");
   chk_conv_kept: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CH_SOFT_RESET != 2'b00 && !hard_q) |-> (CH_CONV_EN == 2'b11))
      else $error("converter stopped by soft reset");
   chk_por_hard: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && POR) |=> hard_q)
      else $error("power-on request did not hard reset");
   chk_pin_glitch: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && pin_sync_q[2] != pin_sync_q[1]) |=> $stable(pin_filt_q))
      else $error("pin change accepted before stages agree");
   chk_hard_state: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && hard_q) |=> (CH_SOFT_RESET == 2'b00))
      else $error("soft state kept through hard reset");
   chk_soft_drop: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && hard_d) |=> (soft_q == 2'b00))
      else $error("soft bits kept through hard reset");
   chk_hard_filter: assert property (@(posedge CLK) disable iff (SYS_RST)
      hard_q |-> (FILTER_RST && CH_CONV_EN == 2'b00))
      else $error("filters not held in hard reset");
   chk_soft_state0: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !hard_q && soft_q[0] && st_q[0] == ASR_ST_RUN) |=> CH_SOFT_RESET[0])
      else $error("ch0 did not enter soft reset");
   chk_soft_state1: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !hard_q && soft_q[1] && st_q[1] == ASR_ST_RUN) |=> CH_SOFT_RESET[1])
      else $error("ch1 did not enter soft reset");
   // Two-wire hosts cannot touch the soft bits, so they must hold
   chk_twowire_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CE && !SPI_MODE && !hard_d) |=> $stable(soft_q))
      else $error("soft bits changed in two-wire mode");

   cov_soft_exit: cover property (@(posedge CLK) disable iff (SYS_RST) CH_RESYNC[0]);
   cov_drdy: cover property (@(posedge CLK) disable iff (SYS_RST) DRDY1 && CH_SOFT_RESET[0]);
   cov_hard_rel: cover property (@(posedge CLK) disable iff (SYS_RST) $fell(hard_q));
   cov_por: cover property (@(posedge CLK) disable iff (SYS_RST) CE && POR);
   cov_freeze: cover property (@(posedge CLK) disable iff (SYS_RST) !CE);
endmodule // asr_reset_ctrl
`default_nettype wire

// ### rtl/asr_cfg.svh
// Constants for the converter soft and hard reset control block
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_NCH 2
`define ASR_DW 24
`define ASR_CMP_RST 4'h3
`define ASR_CMP_W 4
`define ASR_SRST_CH0 0
`define ASR_SRST_CH1 1
`define ASR_SETTLE_DEF 16'h0010
`define ASR_SETTLE_W 16
`endif

// ### rtl/asr_pkg.sv
// Types for the converter soft and hard reset control block
package asr_pkg;
   typedef enum logic [2:0] {
      ASR_ST_HARD = 3'b001,
      ASR_ST_SOFT = 3'b010,
      ASR_ST_RUN = 3'b100
   } asr_state_e;
endpackage

// ### verification/asr_host_model.sv
// Host controller model driving mode, soft reset bits and the reset pin
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
   input wire logic CLK,
   output logic SPI_MODE,
   output logic [1:0] SOFT_RESET_BITS,
   output logic RESET_N_PIN
);
   initial begin
      SPI_MODE = 1'b1;
      SOFT_RESET_BITS = 2'h0;
      RESET_N_PIN = 1'b1;
   end
   // Soft bits only written in SPI mode, bit n for channel n
   task automatic set_soft(input logic [1:0] bits);
      @(posedge CLK);
      if (SPI_MODE) SOFT_RESET_BITS <= bits;
   endtask
   // Pin resets only in SPI mode; two-wire mode ignores the pin level
   task automatic set_pin(input logic mode, input logic level);
      @(posedge CLK);
      SPI_MODE <= mode;
      RESET_N_PIN <= level;
   endtask
endmodule // asr_host_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the converter reset control block
`timescale 1ns/10ps
`default_nettype none
`include "asr_cfg.svh"
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic spi_mode;
   logic reset_n_pin;
   logic [1:0] soft_bits;
   logic ce = 1'b1;
   logic por = 1'b0;
   logic strobe0 = 1'b0;
   logic strobe1 = 1'b0;
   logic [23:0] data0 = 24'h0;
   logic [23:0] data1 = 24'h0;
   logic [3:0] cmp_in = 4'hA;
   logic [23:0] result0, result1;
   logic drdy0, drdy1, filter_rst, serial_rst, bias_en, input_clk_en, hard_reset;
   logic [3:0] cmp0_out, cmp1_out;
   logic [1:0] ch_soft_reset, ch_resync;
   logic s;
   int miscompares = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   asr_host_model host_u (.CLK(clk), .SPI_MODE(spi_mode), .SOFT_RESET_BITS(soft_bits),
      .RESET_N_PIN(reset_n_pin));
   // Short settle count keeps the run brief
   asr_reset_ctrl dut_u (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .POR(por),
      .RESET_N_PIN(reset_n_pin), .SPI_MODE(spi_mode), .SOFT_RESET_BITS(soft_bits),
      .SETTLE_CYCLES(16'h0004), .CONV0_DATA(data0), .CONV1_DATA(data1),
      .CONV0_STROBE(strobe0), .CONV1_STROBE(strobe1), .CMP0_IN(cmp_in), .CMP1_IN(cmp_in),
      .RESULT0(result0), .RESULT1(result1), .DRDY0(drdy0), .DRDY1(drdy1),
      .CMP0_OUT(cmp0_out), .CMP1_OUT(cmp1_out), .CH_SOFT_RESET(ch_soft_reset),
      .CH_CONV_EN(), .CH_RESYNC(ch_resync), .FILTER_RST(filter_rst),
      .SERIAL_RST(serial_rst), .BIAS_EN(bias_en), .INPUT_CLK_EN(input_clk_en),
      .HARD_RESET(hard_reset));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One strobe, then watch that channel's ready line for three cycles
   task automatic pulse(input int ch, input logic [23:0] d, output logic seen);
      @(posedge clk);
      strobe0 <= (ch == 0);
      strobe1 <= (ch == 1);
      data0 <= d;
      data1 <= d;
      @(posedge clk);
      strobe0 <= 1'b0;
      strobe1 <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         #1;
         if ((ch == 0 ? drdy0 : drdy1) === 1'b1) seen = 1'b1;
         @(posedge clk);
      end
   endtask
   task automatic t_reset;
      repeat (2) @(posedge clk);
      #1;
      check("hard", hard_reset, 1);
      check("cmp0", cmp0_out, 4'h3);
      check("bias", bias_en, 1);
      @(posedge clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   task automatic t_run;
      pulse(0, 24'h123456, s);
      check("drdy0", s, 1);
      check("res0", result0, 24'h123456);
      pulse(1, 24'h0ABCDE, s);
      check("res1", result1, 24'h0ABCDE);
   endtask
   task automatic t_soft;
      host_u.set_soft(2'b01);
      repeat (3) @(posedge clk);
      #1;
      check("soft", ch_soft_reset, 2'b01);
      check("res0", result0, 0);
      check("res1", result1, 24'h0ABCDE);
      pulse(0, 24'h111111, s);
      check("drdy0", s, 0);
      check("res0", result0, 0);
      pulse(1, 24'h222222, s);
      check("drdy1", s, 1);
      check("iclk", input_clk_en, 1);
      host_u.set_soft(2'b00);
      s = 1'b0;
      repeat (6) begin
         @(posedge clk);
         #1;
         if (ch_resync[0] === 1'b1) s = 1'b1;
      end
      check("resync", s, 1);
      host_u.set_soft(2'b11);
      repeat (3) @(posedge clk);
      #1;
      check("iclk", input_clk_en, 1);
      host_u.set_soft(2'b10);
      repeat (10) @(posedge clk);
      pulse(0, 24'h333333, s);
      check("drdy0", s, 1);
   endtask
   task automatic t_pin;
      host_u.set_pin(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      #1;
      check("hard", hard_reset, 1);
      check("cmp1", cmp1_out, 4'h3);
      check("res0", result0, 0);
      check("filt", filter_rst, 1);
      check("ser", serial_rst, 1);
      check("soft", ch_soft_reset, 0);
      host_u.set_pin(1'b1, 1'b1);
      host_u.set_soft(2'b00);
      host_u.set_pin(1'b0, 1'b0);
      repeat (6) @(posedge clk);
      #1;
      check("hard", hard_reset, 0);
      host_u.set_pin(1'b1, 1'b1);
      repeat (10) @(posedge clk);
   endtask
   task automatic t_ce_por;
      @(posedge clk);
      ce <= 1'b0;
      cmp_in <= 4'h5;
      host_u.set_soft(2'b01);
      repeat (4) @(posedge clk);
      #1;
      check("frozen", ch_soft_reset, 2'b00);
      check("cmp0", cmp0_out, 4'h5);
      @(posedge clk);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("soft", ch_soft_reset, 2'b01);
      host_u.set_soft(2'b00);
      @(posedge clk);
      por <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("hard", hard_reset, 1);
      check("cmp1", cmp1_out, 4'h3);
      @(posedge clk);
      por <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("hard", hard_reset, 0);
   endtask
   initial begin
      t_reset();
      t_run();
      t_soft();
      t_pin();
      t_ce_por();
      end_of_test();
   end
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
